//--- common/pc_stack_pkg.sv
// Package: register map, field layouts, commands and reset values for the PC and stack block
package pc_stack_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int PC_W    = 15;
    localparam int HI_W    = 7;
    localparam int IDX_W   = 5;
    localparam int DEPTH   = 16;
    localparam int ADDR_W  = 4;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [ADDR_W-1:0] OFF_PC_LOW     = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_PC_HOLD    = 4'h1;
    localparam logic [ADDR_W-1:0] OFF_STK_LOW    = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_STK_HIGH   = 4'h3;
    localparam logic [ADDR_W-1:0] OFF_STK_INDEX  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_STK_STATUS = 4'h5;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int STS_OVF_BIT = 0;
    localparam int STS_UNF_BIT = 1;
    localparam logic [IDX_W-1:0] IDX_EMPTY   = 5'h1f;
    localparam logic [IDX_W-1:0] IDX_LAST    = 5'h0f;
    localparam logic [PC_W-1:0]  PC_RESET    = 15'h0000;
    localparam logic [HI_W-1:0]  HOLD_RESET  = 7'h00;

    // ****************************************
    // Core operations
    // ****************************************
    typedef enum logic [3:0] {
        OP_NONE,
        OP_STEP,
        OP_CALL_ABS,
        OP_CALL_WORK,
        OP_BRANCH_WORK,
        OP_BRANCH_REL,
        OP_RETURN,
        OP_INTERRUPT
    } pc_op_t;

    typedef struct packed {
        pc_op_t      op;
        logic [10:0] operand;
        logic [7:0]  working;
    } core_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

endpackage

//--- rtl/pc_stack.sv
// Program counter loading and 16-level return-address stack
//
// Our own choices: the register offsets and the address-and-strobe port.
module pc_stack
    import pc_stack_pkg::*;
#(
    parameter int STACK_DEPTH = DEPTH
) (
    // Clock and reset
    input  wire logic                   ref_clk,
    input  wire logic                   resetn,
    // Configuration
    input  wire logic                   stack_fault_reset_enable,
    // Core command
    input  wire pc_stack_pkg::core_cmd_t cmd,
    // Register port
    input  wire pc_stack_pkg::reg_req_t  req,
    output logic [7:0]                   rdata,
    // Status
    output logic [PC_W-1:0]              pc,
    output logic                         stack_overflow_flag,
    output logic                         stack_underflow_flag,
    output logic                         stack_fault_reset
);
    import pc_stack_pkg::*;

    // ****************************************
    // State
    // ****************************************
    logic [PC_W-1:0]  pc_ff;
    logic [PC_W-1:0]  nxt_pc;
    logic [HI_W-1:0]  hold_ff;
    logic [IDX_W-1:0] idx_ff;
    logic [IDX_W-1:0] nxt_idx;
    logic [PC_W-1:0]  stack_mem [STACK_DEPTH];
    logic             ovf_ff;
    logic             unf_ff;
    logic             fault_ff;
    logic [7:0]       rdata_ff;

    // Decoded events
    logic             is_push;
    logic             is_pop;
    logic             wr_low;
    logic             wr_hold;
    logic             wr_idx;
    logic             wr_stk_low;
    logic             wr_stk_high;
    logic             wr_sts;
    logic             push_ovf;
    logic             pop_unf;
    logic [3:0]       slot;
    logic [3:0]       push_slot;
    logic [PC_W-1:0]  top_entry;
    logic [PC_W-1:0]  pc_plus1;
    logic [PC_W-1:0]  rel_off;

    // ****************************************
    // Decode
    // ****************************************
    assign is_push     = (cmd.op == OP_CALL_ABS) || (cmd.op == OP_CALL_WORK)
                       || (cmd.op == OP_INTERRUPT);
    assign is_pop      = (cmd.op == OP_RETURN);
    assign wr_low      = req.wr && (req.addr == OFF_PC_LOW);
    assign wr_hold     = req.wr && (req.addr == OFF_PC_HOLD);
    assign wr_stk_low  = req.wr && (req.addr == OFF_STK_LOW);
    assign wr_stk_high = req.wr && (req.addr == OFF_STK_HIGH);
    assign wr_idx      = req.wr && (req.addr == OFF_STK_INDEX);
    assign wr_sts      = req.wr && (req.addr == OFF_STK_STATUS);
    assign slot        = idx_ff[3:0];
    assign push_slot   = nxt_idx[3:0];
    assign top_entry   = stack_mem[slot];
    assign pc_plus1    = pc_ff + 15'h0001;
    assign rel_off     = {{6{cmd.operand[8]}}, cmd.operand[8:0]};
    // Overflow once index leaves the top valid slot, underflow once it leaves the empty mark
    assign push_ovf    = is_push && (idx_ff == IDX_LAST);
    assign pop_unf     = is_pop && (idx_ff == IDX_EMPTY);

    // ****************************************
    // Next program counter
    // ****************************************
    always_comb begin
        nxt_pc = pc_ff;
        unique case (cmd.op)
            OP_NONE:        nxt_pc = pc_ff;
            OP_STEP:        nxt_pc = pc_plus1;
            OP_CALL_ABS:    nxt_pc = {hold_ff[6:3], cmd.operand};
            OP_CALL_WORK:   nxt_pc = {hold_ff, cmd.working};
            OP_BRANCH_WORK: nxt_pc = pc_plus1 + {7'h00, cmd.working};
            OP_BRANCH_REL:  nxt_pc = pc_plus1 + rel_off;
            OP_RETURN:      nxt_pc = top_entry;
            OP_INTERRUPT:   nxt_pc = {7'h00, cmd.working};
            default:        nxt_pc = pc_ff;
        endcase
        // Low-byte write carries the latch into the upper bits
        if (wr_low) begin
            nxt_pc = {hold_ff, req.wdata};
        end
    end

    // ****************************************
    // Next stack index
    // ****************************************
    always_comb begin
        nxt_idx = idx_ff;
        if (wr_idx) begin
            nxt_idx = req.wdata[IDX_W-1:0];
        end else if (is_push) begin
            nxt_idx = idx_ff + 5'h01;
            if (push_ovf) begin
                nxt_idx = 5'h00;
            end
        end else if (is_pop) begin
            nxt_idx = idx_ff - 5'h01;
        end
    end

    // Program counter register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            pc_ff <= PC_RESET;
        end else begin
            pc_ff <= nxt_pc;
        end
    end

    // Holding latch, written only by software
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            hold_ff <= HOLD_RESET;
        end else if (wr_hold) begin
            hold_ff <= req.wdata[HI_W-1:0];
        end
    end

    // Stack index register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            idx_ff <= IDX_EMPTY;
        end else begin
            idx_ff <= nxt_idx;
        end
    end

    // ****************************************
    // Stack storage, private to this block
    // ****************************************
    genvar gi;
    generate
        for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_entry
            always_ff @(posedge ref_clk or negedge resetn) begin
                if (!resetn) begin
                    stack_mem[gi] <= PC_RESET;
                end else if (is_push && !wr_idx && (push_slot == 4'(gi))) begin
                    stack_mem[gi] <= pc_plus1;
                end else if (wr_stk_low && (slot == 4'(gi))) begin
                    stack_mem[gi][7:0] <= req.wdata;
                end else if (wr_stk_high && (slot == 4'(gi))) begin
                    stack_mem[gi][PC_W-1:8] <= req.wdata[HI_W-1:0];
                end
            end
        end
    endgenerate

    // ****************************************
    // Fault flags; a set beats a software clear
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ovf_ff <= 1'b0;
            unf_ff <= 1'b0;
        end else begin
            ovf_ff <= push_ovf || (ovf_ff && !(wr_sts && req.wdata[STS_OVF_BIT]));
            unf_ff <= pop_unf || (unf_ff && !(wr_sts && req.wdata[STS_UNF_BIT]));
        end
    end

    // Reset request, a one-cycle pulse to the reset controller
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            fault_ff <= 1'b0;
        end else begin
            fault_ff <= stack_fault_reset_enable && (push_ovf || pop_unf);
        end
    end

    // ****************************************
    // Read port, data one cycle after strobe
    // ****************************************
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_ff <= 8'h00;
        end else if (req.rd) begin
            unique case (req.addr)
                OFF_PC_LOW:     rdata_ff <= pc_ff[7:0];
                OFF_PC_HOLD:    rdata_ff <= {1'b0, hold_ff};
                OFF_STK_LOW:    rdata_ff <= top_entry[7:0];
                OFF_STK_HIGH:   rdata_ff <= {1'b0, top_entry[PC_W-1:8]};
                OFF_STK_INDEX:  rdata_ff <= {3'h0, idx_ff};
                OFF_STK_STATUS: rdata_ff <= {6'h00, unf_ff, ovf_ff};
                default:        rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    // Outputs
    assign rdata                = rdata_ff;
    assign pc                   = pc_ff;
    assign stack_overflow_flag  = ovf_ff;
    assign stack_underflow_flag = unf_ff;
    assign stack_fault_reset    = fault_ff;

endmodule

//--- tb/pc_stack_properties.sv
// Checker: port-level timing properties of the program counter and stack block
module pc_stack_properties
    import pc_stack_pkg::*;
(
    // Clock and reset
    input wire logic                    ref_clk,
    input wire logic                    resetn,
    // Stimulus side
    input wire logic                    stack_fault_reset_enable,
    input wire pc_stack_pkg::core_cmd_t cmd,
    input wire pc_stack_pkg::reg_req_t  req,
    // Result side
    input wire logic [7:0]              rdata,
    input wire logic [PC_W-1:0]         pc,
    input wire logic                    stack_overflow_flag,
    input wire logic                    stack_underflow_flag,
    input wire logic                    stack_fault_reset
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    a_step_adds_one: assert property (cmd.op == OP_STEP && !req.wr |=>
        pc == $past(pc) + 15'h1) else $error("pc step wrong");
    a_call_abs_target: assert property (cmd.op == OP_CALL_ABS && !req.wr |=>
        pc[10:0] == $past(cmd.operand)) else $error("call target wrong");
    a_call_work_low: assert property (cmd.op == OP_CALL_WORK && !req.wr |=>
        pc[7:0] == $past(cmd.working)) else $error("call low byte wrong");
    a_branch_work_sum: assert property (cmd.op == OP_BRANCH_WORK && !req.wr |=>
        pc == $past(pc) + 15'h1 + {7'h00, $past(cmd.working)})
        else $error("branch through working target wrong");
    a_branch_rel_sum: assert property (cmd.op == OP_BRANCH_REL && !req.wr |=>
        pc == $past(pc) + 15'h1 + {{6{$past(cmd.operand[8])}}, $past(cmd.operand[8:0])})
        else $error("relative branch target wrong");
    a_low_write_load: assert property (req.wr && req.addr == OFF_PC_LOW |=>
        pc[7:0] == $past(req.wdata)) else $error("low write lost");
    a_read_idle_zero: assert property (!req.rd |=> rdata == 8'h00)
        else $error("rdata not idle");
    a_fault_pulse_once: assert property (stack_fault_reset |->
        $past(stack_fault_reset_enable) ##1 !stack_fault_reset) else $error("fault pulse bad");
endmodule

bind pc_stack pc_stack_properties u_props (
    .ref_clk(ref_clk), .resetn(resetn), .stack_fault_reset_enable(stack_fault_reset_enable),
    .cmd(cmd), .req(req), .rdata(rdata), .pc(pc), .stack_overflow_flag(stack_overflow_flag),
    .stack_underflow_flag(stack_underflow_flag), .stack_fault_reset(stack_fault_reset)
);

//--- tb/core_model.sv
// Partner: core execution model issuing one operation per call
module core_model
    import pc_stack_pkg::*;
(
    // Clock
    input wire logic              ref_clk,
    // Operation to the block
    output pc_stack_pkg::core_cmd_t cmd
);
    timeunit 1ns;
    timeprecision 1ns;

    initial cmd = '{OP_NONE, 11'h000, 8'h00};

    // One op for one cycle, then idle; index edits never race an interrupt
    // Targets are given whole, no low-byte table arithmetic
    task automatic run(pc_op_t op, logic [10:0] opd, logic [7:0] w);
        @(posedge ref_clk);
        cmd <= '{op, opd, w};
        @(posedge ref_clk);
        cmd.op <= OP_NONE;
        #1;
    endtask
endmodule

//--- tb/tb.sv
// Testbench: register, core operation and stack scenarios
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pc_stack_pkg::*;

    logic            ref_clk = 1'b0;
    logic            resetn = 1'b0;
    logic            stack_fault_reset_enable = 1'b0;
    core_cmd_t       cmd;
    reg_req_t        req = '0;
    logic [7:0]      rdata;
    logic [PC_W-1:0] pc;
    logic            ovf;
    logic            unf;
    logic            fault;
    int              error_cnt = 0;
    int              tests_run = 0;

    // 25 MHz clock
    always #20 ref_clk = ~ref_clk;

    core_model u_core (.ref_clk(ref_clk), .cmd(cmd));
    pc_stack #(.STACK_DEPTH(DEPTH)) u_dut (
        .ref_clk(ref_clk), .resetn(resetn), .stack_fault_reset_enable(stack_fault_reset_enable),
        .cmd(cmd), .req(req), .rdata(rdata), .pc(pc), .stack_overflow_flag(ovf),
        .stack_underflow_flag(unf), .stack_fault_reset(fault));

    task automatic chk(string name, logic [14:0] exp, logic [14:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic reg_wr(logic [3:0] a, logic [7:0] d);
        @(posedge ref_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(logic [3:0] a, logic [7:0] e, string name);
        @(posedge ref_clk);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1;
        chk(name, {7'h00, e}, {7'h00, rdata});
    endtask

    task automatic s_load();
        chk("pc", 15'h0000, pc);
        reg_rd(OFF_STK_INDEX, 8'h1f, "index");
        reg_wr(4'hf, 8'hff);
        reg_rd(4'hf, 8'h00, "unmapped");
        reg_wr(OFF_PC_HOLD, 8'h55);
        reg_wr(OFF_PC_LOW, 8'h3c);
        chk("pc", 15'h553c, pc);
        reg_rd(OFF_PC_HOLD, 8'h55, "latch");
        reg_rd(OFF_PC_LOW, 8'h3c, "pc low");
    endtask

    task automatic s_call();
        u_core.run(OP_CALL_ABS, 11'h123, 8'h00);
        chk("pc", 15'h5123, pc);
        reg_rd(OFF_STK_INDEX, 8'h00, "index");
        reg_rd(OFF_STK_LOW, 8'h3d, "top low");
        reg_rd(OFF_STK_HIGH, 8'h55, "top high");
        reg_rd(OFF_PC_HOLD, 8'h55, "latch");
        u_core.run(OP_RETURN, 11'h000, 8'h00);
        chk("pc", 15'h553d, pc);
        reg_rd(OFF_STK_INDEX, 8'h1f, "index");
    endtask

    task automatic s_other();
        u_core.run(OP_CALL_WORK, 11'h000, 8'h9a);
        chk("pc", 15'h559a, pc);
        u_core.run(OP_INTERRUPT, 11'h000, 8'h04);
        chk("pc", 15'h0004, pc);
        reg_rd(OFF_STK_INDEX, 8'h01, "index");
        u_core.run(OP_RETURN, 11'h000, 8'h00);
        chk("pc", 15'h559b, pc);
        u_core.run(OP_RETURN, 11'h000, 8'h00);
        chk("pc", 15'h553e, pc);
        u_core.run(OP_BRANCH_WORK, 11'h000, 8'hff);
        chk("pc", 15'h563e, pc);
        u_core.run(OP_BRANCH_REL, 11'h1fe, 8'h00);
        chk("pc", 15'h563d, pc);
        u_core.run(OP_STEP, 11'h000, 8'h00);
        chk("pc", 15'h563e, pc);
    endtask

    task automatic s_wrap();
        for (int i = 1; i <= 17; i++) begin
            u_core.run(OP_CALL_ABS, 11'h100 + 11'(i), 8'h00);
        end
        chk("overflow", 15'h0001, {14'h0, ovf});
        chk("fault", 15'h0000, {14'h0, fault});
        reg_rd(OFF_STK_INDEX, 8'h00, "index");
        reg_rd(OFF_STK_LOW, 8'h11, "top low");
        reg_rd(OFF_STK_HIGH, 8'h51, "top high");
        reg_wr(OFF_STK_LOW, 8'h44);
        reg_wr(OFF_STK_HIGH, 8'h22);
        u_core.run(OP_RETURN, 11'h000, 8'h00);
        chk("pc", 15'h2244, pc);
        reg_wr(OFF_STK_STATUS, 8'h03);
        @(posedge ref_clk);
        stack_fault_reset_enable <= 1'b1;
        u_core.run(OP_RETURN, 11'h000, 8'h00);
        chk("underflow", 15'h0001, {14'h0, unf});
        chk("fault", 15'h0001, {14'h0, fault});
    endtask

    // Reset in mid-run with a live program counter and stack
    task automatic s_reset();
        u_core.run(OP_CALL_ABS, 11'h0aa, 8'h00);
        chk("pc", 15'h50aa, pc);
        @(posedge ref_clk);
        resetn <= 1'b0;
        #1;
        chk("pc", 15'h0000, pc);
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        reg_rd(OFF_STK_INDEX, 8'h1f, "index");
        reg_rd(OFF_STK_STATUS, 8'h00, "status");
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Reset, then scenarios in order
    initial begin
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        s_load();
        s_call();
        s_other();
        s_wrap();
        s_reset();
        finish_test();
    end

    // Watchdog well beyond the expected run
    initial begin
        repeat (2000) @(posedge ref_clk);
        error_cnt++;
        finish_test();
    end
endmodule
